// File: inc/usart_sync_rx_regs.svh
// Register offsets, bit positions and reset values of the serial port.
`ifndef USART_SYNC_RX_REGS_SVH
`define USART_SYNC_RX_REGS_SVH
`define OFS_RXCS    8'h13
`define OFS_RXFIFO  8'h14
`define OFS_TXCS    8'h15
`define OFS_IRQREQ  8'h16
`define OFS_IRQEN   8'h17
`define OFS_BAUD    8'h19
`define B_SERIAL_PORT_ENABLE      7
`define B_RX9       6
`define B_SINGLE_RECEIVE_ENABLE      5
`define B_CONTINUOUS_RECEIVE_ENABLE      4
`define B_FRAMING_ERROR      2
`define B_OVERRUN_ERROR      1
`define B_RECEIVED_NINTH_BIT      0
`define B_CLOCK_SOURCE_SELECT      7
`define B_TX9       6
`define B_TRANSMIT_ENABLE_BIT      5
`define B_SYNC      4
`define B_SHIFT_REGISTER_EMPTY      1
`define B_TRANSMIT_NINTH_BIT      0
`define B_RCV_FLAG  0
`define B_RCV_IE    0
`define RST_BYTE    8'h00
`define RST_BAUD    8'h00
`define FIFO_DEPTH  2'h2
`define BITS_8      4'h8
`define BITS_9      4'h9
`endif

// File: inc/usart_sync_rx_pkg.sv
// Types shared by the serial port design.
package usart_sync_rx_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [8:0] word9_t;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_LOW  = 2'b01,
      ST_HIGH = 2'b10
   } rx_state_t;
endpackage : usart_sync_rx_pkg

// File: src/usart_sync_rx.sv
// Serial port setup registers and the synchronous master receive path.
//
// What this block does
// - Pins serve the port only while enabled.
// - Block sets pin directions from config bits.
// - Receives in synchronous master mode only; asynchronous and slave settings only set pin directions.
// - Clock source bit picks master or slave.
// - Nine-bit receive bit selects word length.
// - Setting a receive enable starts reception.
// - Data sampled on serial clock falling edge.
// - Single gets one word; continuous keeps going.
// - Both enables set behaves as continuous.
// - Finished word enters FIFO, sets receive flag.
// - Interrupt raised only while enable bit set.
// - Flag read-only, clears when FIFO empties.
// - Receive register is a two-entry FIFO.
// - Full FIFO at word end sets overrun.
// - Clearing continuous enable clears overrun.
// - Overrun blocks every transfer into FIFO.
// - Ninth bit travels with each FIFO entry.
// - Disabling reception resets the receive logic.
`timescale 1ns/1ps
`include "usart_sync_rx_regs.svh"

module usart_sync_rx
(
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic [7:0]              addr,
   input  wire usart_sync_rx_pkg::byte_t wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output      usart_sync_rx_pkg::byte_t rdata,
   output      logic                    rcv_irq,
   input  wire logic                    data_i,
   output      logic                    data_o,
   output      logic                    data_oe,
   input  wire logic                    clk_i,
   output      logic                    clk_o,
   output      logic                    clk_oe
);
   import usart_sync_rx_pkg::*;

   byte_t     rxcs_q;
   byte_t     txcs_q;
   byte_t     baud_q;
   logic      ie_q;
   byte_t     rdata_q;
   word9_t    fifo_q [0:1];
   logic [1:0] cnt_q;
   logic      overrun_error_q;
   rx_state_t st_q;
   rx_state_t st_d;
   byte_t     div_q;
   logic [3:0] bits_q;
   word9_t    sh_q;
   logic      sck_q;
   logic      dt_m_q;
   logic      dt_s_q;
   logic      ck_m_q;
   logic      ck_s_q;

   // Right-aligns the shifted bits; eight-bit words sit one place high.
   function automatic word9_t align(input word9_t s, input logic nine);
      align = nine ? s : {1'b0, s[8:1]};
   endfunction : align

   wire serial_port_enable = rxcs_q[`B_SERIAL_PORT_ENABLE];
   wire rx9  = rxcs_q[`B_RX9];
   wire single_receive_enable = rxcs_q[`B_SINGLE_RECEIVE_ENABLE];
   wire continuous_receive_enable = rxcs_q[`B_CONTINUOUS_RECEIVE_ENABLE];
   wire sync = txcs_q[`B_SYNC];
   wire clock_source_select = txcs_q[`B_CLOCK_SOURCE_SELECT];
   wire transmit_enable_bit = txcs_q[`B_TRANSMIT_ENABLE_BIT];

   wire sel_rxcs = (addr == `OFS_RXCS);
   wire sel_fifo = (addr == `OFS_RXFIFO);
   wire sel_txcs = (addr == `OFS_TXCS);
   wire sel_ireq = (addr == `OFS_IRQREQ);
   wire sel_ien  = (addr == `OFS_IRQEN);
   wire sel_baud = (addr == `OFS_BAUD);

   // Reception needs the port on, clocked mode and at least one enable.
   wire rx_req = single_receive_enable | continuous_receive_enable;
   wire rx_en  = serial_port_enable & sync & rx_req;
   wire master_rx = rx_en & clock_source_select;

   // A master also drives the clock when only transmit is enabled.
   wire ck_drive = serial_port_enable & ((sync & clock_source_select & (transmit_enable_bit | rx_req)) | (!sync & transmit_enable_bit));
   wire dt_drive = serial_port_enable & sync & transmit_enable_bit & !rx_req;

   wire div_hit  = (div_q == baud_q);
   wire rise     = (st_q == ST_LOW) & div_hit;
   wire sample   = (st_q == ST_HIGH) & div_hit;
   wire [3:0] nbits = rx9 ? `BITS_9 : `BITS_8;
   wire last     = sample & (bits_q == nbits - 4'h1);
   word9_t sh_next;
   assign sh_next = {dt_s_q, sh_q[8:1]};

   wire fifo_full = (cnt_q == `FIFO_DEPTH);
   wire fifo_any  = (cnt_q != 2'h0);
   wire push      = last & !overrun_error_q & !fifo_full;
   wire ovr_set   = last & !overrun_error_q & fifo_full;
   wire pop       = rd & sel_fifo & fifo_any;
   wire continuous_receive_enable_clr  = wr & sel_rxcs & !wdata[`B_CONTINUOUS_RECEIVE_ENABLE];
   wire single_done = push & single_receive_enable & !continuous_receive_enable;

   wire rcv_flag = fifo_any;
   assign rcv_irq = rcv_flag & ie_q;

   word9_t head;
   assign head = fifo_q[0];

   byte_t rxcs_rd;
   assign rxcs_rd = {rxcs_q[7:4], 1'b0, 1'b0, overrun_error_q, head[8] & fifo_any};
   byte_t txcs_rd;
   assign txcs_rd = {txcs_q[7:4], 2'b00, 1'b1, txcs_q[`B_TRANSMIT_NINTH_BIT]};

   byte_t rd_mux;
   assign rd_mux = sel_rxcs ? rxcs_rd :
                   sel_fifo ? head[7:0] :
                   sel_txcs ? txcs_rd :
                   sel_ireq ? {7'h00, rcv_flag} :
                   sel_ien  ? {7'h00, ie_q} :
                   sel_baud ? baud_q : 8'h00;

   // Pin ownership: outside the port the pins are left undriven.
   assign clk_o   = (sync & clock_source_select) ? sck_q : 1'b1;
   assign clk_oe  = ck_drive;
   assign data_o  = txcs_q[`B_TRANSMIT_NINTH_BIT];
   assign data_oe = dt_drive;
   assign rdata   = rdata_q;

   // Two flip-flops before any logic reads the pins.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dt_m_q <= 1'b0;
         dt_s_q <= 1'b0;
         ck_m_q <= 1'b0;
         ck_s_q <= 1'b0;
      end
      else
      begin
         dt_m_q <= data_i;
         dt_s_q <= dt_m_q;
         ck_m_q <= clk_i;
         ck_s_q <= ck_m_q;
      end
   end

   // The clock pin reads back what the master drives, two flops late.
   a_clock_echo: assert property (@(posedge clk) disable iff (sys_rst)
      $past(clk_oe, 2) |-> ck_s_q == $past(clk_o, 2))
      else $error("serial clock pin does not follow the driven clock");

   // Register writes; hardware clears single enable after its word.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rxcs_q  <= `RST_BYTE;
         txcs_q  <= `RST_BYTE;
         baud_q  <= `RST_BAUD;
         ie_q    <= 1'b0;
         rdata_q <= `RST_BYTE;
      end
      else
      begin
         rdata_q <= rd ? rd_mux : `RST_BYTE;
         if (wr & sel_rxcs)
            rxcs_q <= {wdata[7:4], 4'h0};
         else if (single_done)
            rxcs_q[`B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
         if (wr & sel_txcs)
            txcs_q <= {wdata[7:4], 3'b000, wdata[`B_TRANSMIT_NINTH_BIT]};
         if (wr & sel_baud)
            baud_q <= wdata;
         if (wr & sel_ien)
            ie_q <= wdata[`B_RCV_IE];
      end
   end

   // Overrun: set wins over the clear that clearing continuous gives.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         overrun_error_q <= 1'b0;
      else if (ovr_set)
         overrun_error_q <= 1'b1;
      else if (continuous_receive_enable_clr)
         overrun_error_q <= 1'b0;
   end

   // Two-entry FIFO; a push and pop in one cycle keep the count.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_q     <= 2'h0;
         fifo_q[0] <= 9'h000;
         fifo_q[1] <= 9'h000;
      end
      else
      begin
         if (pop)
            fifo_q[0] <= fifo_q[1];
         if (push)
         begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))
               fifo_q[0] <= align(sh_next, rx9);
            else
               fifo_q[1] <= align(sh_next, rx9);
         end
         if (push & !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop & !push)
            cnt_q <= cnt_q - 2'h1;
      end
   end

   // Clock generator and shifter; each half period is divisor+1 cycles.
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:
            st_d = master_rx ? ST_LOW : ST_IDLE;
         ST_LOW:
            st_d = rise ? ST_HIGH : ST_LOW;
         ST_HIGH:
            st_d = sample ? ST_LOW : ST_HIGH;
         default:
            st_d = ST_IDLE;
      endcase
      if (!master_rx)
         st_d = ST_IDLE;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q   <= ST_IDLE;
         div_q  <= 8'h00;
         bits_q <= 4'h0;
         sh_q   <= 9'h000;
         sck_q  <= 1'b0;
      end
      else if (!master_rx)
      begin
         st_q   <= ST_IDLE;
         div_q  <= 8'h00;
         bits_q <= 4'h0;
         sh_q   <= 9'h000;
         sck_q  <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         div_q <= (div_hit || st_q == ST_IDLE) ? 8'h00 : div_q + 8'h01;
         if (rise)
            sck_q <= 1'b1;
         if (sample)
         begin
            sck_q  <= 1'b0;
            sh_q   <= sh_next;
            bits_q <= last ? 4'h0 : bits_q + 4'h1;
         end
      end
   end

   a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
      rcv_irq |-> ie_q && cnt_q != 2'h0)
      else $error("receive interrupt without enable or data");

   a_push_flags: assert property (@(posedge clk) disable iff (sys_rst)
      push && !pop |=> rcv_flag && cnt_q == $past(cnt_q) + 2'h1)
      else $error("finished word did not raise receive flag");

   a_overrun_held: assert property (@(posedge clk) disable iff (sys_rst)
      overrun_error_q && !continuous_receive_enable_clr |=> overrun_error_q)
      else $error("overrun cleared without continuous enable clear");

   a_overrun_clear: assert property (@(posedge clk) disable iff (sys_rst)
      overrun_error_q && continuous_receive_enable_clr && !ovr_set |=> !overrun_error_q)
      else $error("overrun not cleared by continuous enable clear");

   a_overrun_block: assert property (@(posedge clk) disable iff (sys_rst)
      overrun_error_q |-> !push)
      else $error("transfer into FIFO during overrun");

   a_full_overrun: assert property (@(posedge clk) disable iff (sys_rst)
      last && fifo_full && !pop && !(overrun_error_q && continuous_receive_enable_clr) |=> overrun_error_q && cnt_q == `FIFO_DEPTH)
      else $error("full FIFO at word end did not set overrun");

   a_fall_sample: assert property (@(posedge clk) disable iff (sys_rst)
      sample && master_rx |=> !sck_q && $past(sck_q))
      else $error("sample not taken at serial clock fall");

   a_pins_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !serial_port_enable |-> !clk_oe && !data_oe)
      else $error("pins driven while port disabled");

   a_master_pins: assert property (@(posedge clk) disable iff (sys_rst)
      master_rx |-> clk_oe && !data_oe)
      else $error("master receive pin directions wrong");

   a_single_stop: assert property (@(posedge clk) disable iff (sys_rst)
      single_done && !wr |=> !single_receive_enable ##1 st_q == ST_IDLE)
      else $error("single receive did not stop after one word");

   a_disable_reset: assert property (@(posedge clk) disable iff (sys_rst)
      !master_rx |=> st_q == ST_IDLE && bits_q == 4'h0 && !sck_q)
      else $error("receive logic not reset when disabled");

   // The serial clock is high exactly while the generator sits in its high half.
   // Any mismatch here means a sample could land on the wrong edge.
   a_clock_phase: assert property (@(posedge clk) disable iff (sys_rst)
      sck_q == (st_q == ST_HIGH))
      else $error("serial clock level disagrees with generator state");

   a_sample_shift: assert property (@(posedge clk) disable iff (sys_rst)
      sample && master_rx |=> sh_q == $past(sh_next))
      else $error("sampled bit not shifted in at clock fall");

   a_start_rx: assert property (@(posedge clk) disable iff (sys_rst)
      master_rx && st_q == ST_IDLE && !wr |=> st_q == ST_LOW)
      else $error("reception did not start after receive enable");

   a_both_continuous: assert property (@(posedge clk) disable iff (sys_rst)
      push && continuous_receive_enable && !wr |=> master_rx)
      else $error("both enables set did not keep receiving");

   a_cont_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      continuous_receive_enable && !wr |=> continuous_receive_enable)
      else $error("continuous enable dropped without software");

   a_pop_empties: assert property (@(posedge clk) disable iff (sys_rst)
      pop && cnt_q == 2'h1 && !push |=> !rcv_flag)
      else $error("receive flag still set after last entry read");

   a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst)
      cnt_q != 2'h3)
      else $error("FIFO count above two entries");

   a_pop_shift: assert property (@(posedge clk) disable iff (sys_rst)
      pop && cnt_q == `FIFO_DEPTH |=> fifo_q[0] == $past(fifo_q[1]))
      else $error("second FIFO entry did not move to the head");

   a_rx9_align: assert property (@(posedge clk) disable iff (sys_rst)
      push && !rx9 && cnt_q == 2'h0 |=> !fifo_q[0][8])
      else $error("eight-bit word stored with a ninth bit set");

   a_irq_follows: assert property (@(posedge clk) disable iff (sys_rst)
      rcv_flag && ie_q |-> rcv_irq)
      else $error("enabled receive interrupt not raised");

   a_async_pins: assert property (@(posedge clk) disable iff (sys_rst)
      serial_port_enable && !sync |-> !data_oe && clk_oe == transmit_enable_bit)
      else $error("asynchronous pin directions wrong");

   a_rx_priority: assert property (@(posedge clk) disable iff (sys_rst)
      sync && rx_req |-> !data_oe)
      else $error("data pin driven while a receive enable is set");

   a_slave_clock: assert property (@(posedge clk) disable iff (sys_rst)
      sync && !clock_source_select |-> !clk_oe && !master_rx)
      else $error("slave setting drives the serial clock");

endmodule : usart_sync_rx

// File: sim/sync_peripheral.sv
// Clocked serial peripheral that shifts queued words out LSB first.
`timescale 1ns/1ps
module sync_peripheral
(
   input  wire logic clk,
   input  wire logic sck,
   input  wire logic sck_en,
   input  wire logic nine,
   output      logic dout
);
   import usart_sync_rx_pkg::*;
   word9_t q[$];
   word9_t cur   = 9'h0A5;
   int     idx   = 0;
   logic   sck_q = 1'b0;
   initial dout = 1'b0;
   always @(posedge clk)
   begin
      sck_q <= sck;
      if (!sck_en)
      begin
         idx = 0;
         // A released line toggles so a stale bit can never pass for data.
         dout <= ~dout;
      end
      else if (sck && !sck_q)
      begin
         if (idx == 0)
            cur = (q.size() > 0) ? q.pop_front() : ~cur;
         dout <= cur[idx];
         idx = (idx == (nine ? 8 : 7)) ? 0 : idx + 1;
      end
   end
endmodule : sync_peripheral

// File: sim/tb.sv
// Self-checking bench for the synchronous master receive path.
`timescale 1ns/1ps
`include "usart_sync_rx_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb;
   import usart_sync_rx_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, nine = 1'b0;
   logic [7:0]  addr = 8'h00;
   byte_t       wdata = 8'h00, rdata, v;
   logic        rcv_irq, data_o, data_oe, clk_o, clk_oe, pm_dout, ov, ec, ed;
   int          fail_count = 0, checked = 0;
   logic [31:0] seed = 32'hBF45A791, t;
   word9_t      w[3];
   wire         data_line = data_oe ? data_o : pm_dout;
   wire         clk_line = clk_oe ? clk_o : 1'b0;
   usart_sync_rx dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rcv_irq(rcv_irq), .data_i(data_line), .data_o(data_o),
      .data_oe(data_oe), .clk_i(clk_line), .clk_o(clk_o), .clk_oe(clk_oe));
   sync_peripheral pm (.clk(clk), .sck(clk_o), .sck_en(clk_oe), .nine(nine), .dout(pm_dout));
   initial forever #4 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic wr_reg(input logic [7:0] a, input byte_t d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic chk_reg(input logic [7:0] a, input byte_t e);
      rd_reg(a);
      `CHK(v, e)
   endtask : chk_reg
   task automatic wait_irq();
      for (int i = 0; i < 400 && rcv_irq !== 1'b1; i++) @(posedge clk);
      `CHK(rcv_irq, 1'b1)
   endtask : wait_irq
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      #1 `CHK(clk_oe, 1'b0)
      `CHK(data_oe, 1'b0)
      chk_reg(`OFS_TXCS, 8'h02);
      chk_reg(`OFS_RXCS, 8'h00);
      wr_reg(8'h20, 8'hFF);
      chk_reg(8'h20, 8'h00);
      wr_reg(`OFS_TXCS, 8'hFF);
      chk_reg(`OFS_TXCS, 8'hF3);
      $display("register test done");
      // A slow link keeps hardware from ending a single receive mid-check.
      wr_reg(`OFS_BAUD, 8'hFF);
      for (int i = 0; i < 16; i++)
      begin
         t = rnd();
         if (i == 0) t[15] = 1'b0;
         wr_reg(`OFS_TXCS, t[7:0] & 8'hF1);
         wr_reg(`OFS_RXCS, t[15:8] & 8'hB0);
         @(posedge clk);
         ec = t[15] & ((t[4] & t[7] & (t[5] | t[13] | t[12])) | (!t[4] & t[5]));
         ed = t[15] & t[4] & t[5] & !(t[13] | t[12]);
         #1 `CHK(clk_oe, ec)
         `CHK(data_oe, ed)
         `CHK(data_o & data_oe, t[0] & ed)
         `CHK(clk_o, !(t[4] & t[7]))
      end
      wr_reg(`OFS_RXCS, 8'h00);
      rd_reg(`OFS_RXFIFO);
      rd_reg(`OFS_RXFIFO);
      $display("pin direction test done");
      wr_reg(`OFS_BAUD, 8'h03);
      chk_reg(`OFS_BAUD, 8'h03);
      wr_reg(`OFS_TXCS, 8'h90);
      wr_reg(`OFS_IRQEN, 8'h01);
      nine = 1'b1;
      t = rnd();
      w[0] = t[8:0];
      pm.q.push_back(w[0]);
      wr_reg(`OFS_RXCS, 8'hE0);
      repeat (3) @(posedge clk);
      #1 `CHK(clk_oe, 1'b1)
      `CHK(data_oe, 1'b0)
      wait_irq();
      chk_reg(`OFS_RXCS, {7'b1100000, w[0][8]});
      chk_reg(`OFS_IRQREQ, 8'h01);
      wr_reg(`OFS_IRQEN, 8'h00);
      @(posedge clk);
      #1 `CHK(rcv_irq, 1'b0)
      chk_reg(`OFS_RXFIFO, w[0][7:0]);
      chk_reg(`OFS_IRQREQ, 8'h00);
      wr_reg(`OFS_IRQREQ, 8'h01);
      chk_reg(`OFS_IRQREQ, 8'h00);
      repeat (150) @(posedge clk);
      chk_reg(`OFS_IRQREQ, 8'h00);
      $display("single receive test done");
      for (int i = 0; i < 3; i++)
      begin
         t = rnd();
         w[i] = t[8:0];
         pm.q.push_back(w[i]);
      end
      wr_reg(`OFS_RXCS, 8'hF0);
      ov = 1'b0;
      for (int i = 0; i < 400 && !ov; i++)
      begin
         rd_reg(`OFS_RXCS);
         ov = v[1];
      end
      `CHK(v[1], 1'b1)
      `CHK(v[0], w[0][8])
      chk_reg(`OFS_RXFIFO, w[0][7:0]);
      repeat (100) @(posedge clk);
      rd_reg(`OFS_RXCS);
      `CHK(v[0], w[1][8])
      `CHK(v[1], 1'b1)
      chk_reg(`OFS_RXFIFO, w[1][7:0]);
      chk_reg(`OFS_IRQREQ, 8'h00);
      wr_reg(`OFS_RXCS, 8'hC0);
      rd_reg(`OFS_RXCS);
      `CHK(v[1], 1'b0)
      `CHK(clk_oe, 1'b0)
      nine = 1'b0;
      pm.q.delete();
      t = rnd();
      w[2] = t[8:0];
      pm.q.push_back(w[2]);
      wr_reg(`OFS_IRQEN, 8'h01);
      wr_reg(`OFS_RXCS, 8'hA0);
      wait_irq();
      chk_reg(`OFS_RXCS, 8'h80);
      chk_reg(`OFS_RXFIFO, w[2][7:0]);
      $display("continuous and overrun test done");
      finish_test();
   end
endmodule : tb
